/* tcip_consts.svh */
// Offsets, field positions, codes and reset values of the timer block
`ifndef TCIP_CONSTS_SVH
`define TCIP_CONSTS_SVH
`define TCIP_ADDR_CTRL_B   3'h0
`define TCIP_ADDR_CNT      3'h1
`define TCIP_ADDR_OCR_A    3'h2
`define TCIP_ADDR_OCR_B    3'h3
`define TCIP_ADDR_MASK     3'h4
`define TCIP_ADDR_FLAGS    3'h5
`define TCIP_ADDR_SYNC     3'h6
`define TCIP_BIT_FORCE_A   7
`define TCIP_BIT_FORCE_B   6
`define TCIP_BIT_WGM2      3
`define TCIP_CS_MSB        2
`define TCIP_BIT_IRQ_B     3
`define TCIP_BIT_IRQ_A     2
`define TCIP_BIT_IRQ_OVF   1
`define TCIP_BIT_TSM       7
`define TCIP_BIT_PSR       0
`define TCIP_CS_STOP       3'h0
`define TCIP_CS_DIRECT     3'h1
`define TCIP_CS_DIV8       3'h2
`define TCIP_CS_DIV64      3'h3
`define TCIP_CS_DIV256     3'h4
`define TCIP_CS_DIV1024    3'h5
`define TCIP_CS_EXT_FALL   3'h6
`define TCIP_CS_EXT_RISE   3'h7
`define TCIP_MODE_NORMAL   3'h0
`define TCIP_MODE_CTC      3'h2
`define TCIP_MODE_FAST_OCR 3'h7
`define TCIP_LO_FAST       2'h3
`define TCIP_LO_PHASE      2'h1
`define TCIP_OM_TOGGLE     2'h1
`define TCIP_OM_CLEAR      2'h2
`define TCIP_OM_SET        2'h3
`define TCIP_MAX           8'hFF
`define TCIP_BOTTOM        8'h00
`define TCIP_ONE           8'h01
`define TCIP_RST_BYTE      8'h00
`define TCIP_RST_SEL       3'h0
`define TCIP_PSC_W         10
`define TCIP_TAP8_MSB      2
`define TCIP_TAP64_MSB     5
`define TCIP_TAP256_MSB    7
`define TCIP_TAP1024_MSB   9
`endif

/* tcip_pin_edge.sv */
// Count-pin sampler and edge detector
module tcip_pin_edge (
	input  wire logic      i_sys_clk,
	input  wire logic      i_rst,
	input  wire logic      i_pin,
	tcip_tick_if.pin_side  tick
);
	import tcip_pkg::*;

	logic samp_r;
	logic cur_r;
	logic old_r;

	// Pin is read regardless of its direction, so software can count
	assign tick.ext_rise = cur_r & ~old_r;
	assign tick.ext_fall = ~cur_r & old_r;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			samp_r <= 1'b0;
			cur_r  <= 1'b0;
			old_r  <= 1'b0;
		end else begin
			samp_r <= i_pin;
			cur_r  <= samp_r;
			old_r  <= cur_r;
		end
	end
endmodule

/* tcip_pkg.sv */
// Types shared by the timer block modules
package tcip_pkg;
	typedef logic [7:0] tcip_byte_t;
	typedef logic [2:0] tcip_addr_t;
	typedef logic [2:0] tcip_sel_t;
	typedef enum logic [1:0] {
		TCIP_DIR_UP = 2'b01,
		TCIP_DIR_DN = 2'b10
	} tcip_dir_t;
endpackage

/* tcip_prescaler.sv */
// Free-running prescaler producing the divided tick taps
`include "tcip_consts.svh"
module tcip_prescaler (
	input  wire logic   i_sys_clk,
	input  wire logic   i_rst,
	input  wire logic   i_clear,
	tcip_tick_if.presc  tick
);
	import tcip_pkg::*;

	logic [`TCIP_PSC_W-1:0] cnt_r;
	logic [`TCIP_PSC_W-1:0] cnt_nxt;

	// Never looks at clock select, so tap phase survives reselection
	assign cnt_nxt = i_clear ? '0 : cnt_r + 1'b1;
	assign tick.tap8    = &cnt_r[`TCIP_TAP8_MSB:0] & ~i_clear;
	assign tick.tap64   = &cnt_r[`TCIP_TAP64_MSB:0] & ~i_clear;
	assign tick.tap256  = &cnt_r[`TCIP_TAP256_MSB:0] & ~i_clear;
	assign tick.tap1024 = &cnt_r[`TCIP_TAP1024_MSB:0] & ~i_clear;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

/* tcip_tick_if.sv */
// Tick pulses from prescaler and count-pin detector to the timer core
interface tcip_tick_if;
	logic tap8;
	logic tap64;
	logic tap256;
	logic tap1024;
	logic ext_rise;
	logic ext_fall;
	modport presc (output tap8, output tap64, output tap256, output tap1024);
	modport pin_side (output ext_rise, output ext_fall);
	modport core (input tap8, input tap64, input tap256, input tap1024,
		input ext_rise, input ext_fall);
endinterface

/* tcip_timer.sv */
// Timer/counter with two compare channels, flags and prescaler control
//
// Our own choices: the address map and the plain strobed port.
`include "tcip_consts.svh"

module tcip_timer (
	input  wire logic               i_sys_clk,
	input  wire logic               i_rst,
	input  wire tcip_pkg::tcip_addr_t i_addr,
	input  wire tcip_pkg::tcip_byte_t i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	input  wire logic [1:0]         i_wave_mode_lo,
	input  wire logic [1:0]         i_out_mode_a,
	input  wire logic [1:0]         i_out_mode_b,
	input  wire logic               i_ext_count_pin,
	input  wire logic               i_global_irq_en,
	input  wire logic               i_vec_ack_cmp_a,
	input  wire logic               i_vec_ack_cmp_b,
	input  wire logic               i_vec_ack_ovf,
	output tcip_pkg::tcip_byte_t    o_rdata,
	output logic                    o_irq_cmp_a,
	output logic                    o_irq_cmp_b,
	output logic                    o_irq_ovf,
	output logic                    o_wave_out_a,
	output logic                    o_wave_out_b
);
	import tcip_pkg::*;

	tcip_tick_if tick_if ();

	tcip_byte_t cnt_r;
	tcip_byte_t cnt_nxt;
	tcip_byte_t ocr_a_r;
	tcip_byte_t ocr_b_r;
	tcip_byte_t rd_mux;
	tcip_byte_t rdata_r;
	tcip_byte_t top_val;
	tcip_sel_t  clk_sel_r;
	tcip_sel_t  wave_mode;
	tcip_dir_t  dir_r;
	tcip_dir_t  dir_nxt;
	logic       wgm2_r;
	logic [2:0] mask_r;
	logic [2:0] flag_r;
	logic [2:0] flag_nxt;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic [2:0] irq_r;
	logic       force_a_r;
	logic       force_b_r;
	logic       blk_r;
	logic       psr_r;
	logic       psr_nxt;
	logic       tsm_r;
	logic       wave_a_r;
	logic       wave_b_r;
	logic       wr_ctrl;
	logic       wr_cnt;
	logic       wr_ocr_a;
	logic       wr_ocr_b;
	logic       wr_mask;
	logic       wr_flags;
	logic       wr_sync;
	logic       is_pwm;
	logic       is_phase;
	logic       top_is_ocr;
	logic       at_top;
	logic       tick_raw;
	logic       tick;
	logic       eq_a;
	logic       eq_b;
	logic       match_a;
	logic       match_b;
	logic       hit_a;
	logic       hit_b;
	logic       top_evt;
	logic       ovf_set;
	logic       force_a_nxt;
	logic       force_b_nxt;

	tcip_prescaler u_presc (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_clear   (psr_r),
		.tick      (tick_if.presc)
	);

	tcip_pin_edge u_pin (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_pin     (i_ext_count_pin),
		.tick      (tick_if.pin_side)
	);

	// Next state of one flag; a set in the clearing cycle wins
	function automatic logic flag_next(input logic cur, input logic set,
		input logic clr);
		flag_next = set | (cur & ~clr);
	endfunction

	// Next level of one waveform output for its output mode
	function automatic logic wave_next(input logic cur,
		input logic [1:0] om, input logic hit, input logic top,
		input logic pwm, input logic phase, input logic up,
		input logic tog_ok);
		logic res;
		res = cur;
		if (hit) begin
			case (om)
				`TCIP_OM_TOGGLE: res = (!pwm || tog_ok) ? ~cur : cur;
				`TCIP_OM_CLEAR:  res = phase ? ~up : 1'b0;
				`TCIP_OM_SET:    res = phase ? up : 1'b1;
				default:         res = cur;
			endcase
		end else if (top && pwm && !phase) begin
			case (om)
				`TCIP_OM_CLEAR: res = 1'b1;
				`TCIP_OM_SET:   res = 1'b0;
				default:        res = cur;
			endcase
		end
		wave_next = res;
	endfunction

	// Register decode
	assign wr_ctrl  = i_wr & (i_addr == `TCIP_ADDR_CTRL_B);
	assign wr_cnt   = i_wr & (i_addr == `TCIP_ADDR_CNT);
	assign wr_ocr_a = i_wr & (i_addr == `TCIP_ADDR_OCR_A);
	assign wr_ocr_b = i_wr & (i_addr == `TCIP_ADDR_OCR_B);
	assign wr_mask  = i_wr & (i_addr == `TCIP_ADDR_MASK);
	assign wr_flags = i_wr & (i_addr == `TCIP_ADDR_FLAGS);
	assign wr_sync  = i_wr & (i_addr == `TCIP_ADDR_SYNC);

	// Mode decode; odd low mode bit means a PWM mode
	assign wave_mode  = {wgm2_r, i_wave_mode_lo};
	assign is_pwm     = i_wave_mode_lo[0];
	assign is_phase   = i_wave_mode_lo == `TCIP_LO_PHASE;
	assign top_is_ocr = (wave_mode == `TCIP_MODE_CTC) | (wgm2_r & is_pwm);
	assign top_val    = top_is_ocr ? ocr_a_r : `TCIP_MAX;
	assign at_top     = cnt_r == top_val;

	// Clock source select
	assign tick_raw =
		(clk_sel_r == `TCIP_CS_DIRECT)   ? 1'b1 :
		(clk_sel_r == `TCIP_CS_DIV8)     ? tick_if.tap8 :
		(clk_sel_r == `TCIP_CS_DIV64)    ? tick_if.tap64 :
		(clk_sel_r == `TCIP_CS_DIV256)   ? tick_if.tap256 :
		(clk_sel_r == `TCIP_CS_DIV1024)  ? tick_if.tap1024 :
		(clk_sel_r == `TCIP_CS_EXT_FALL) ? tick_if.ext_fall :
		(clk_sel_r == `TCIP_CS_EXT_RISE) ? tick_if.ext_rise :
		1'b0;
	// Held prescaler reset keeps the counter halted during setup
	assign tick = tick_raw & ~psr_r;

	// Compare units
	assign eq_a    = cnt_r == ocr_a_r;
	assign eq_b    = cnt_r == ocr_b_r;
	assign match_a = tick & ~blk_r & eq_a;
	assign match_b = tick & ~blk_r & eq_b;
	assign top_evt = tick & at_top;

	// Force strobes only in non-PWM modes; they never reach the flags
	assign force_a_nxt = wr_ctrl & i_wdata[`TCIP_BIT_FORCE_A] &
		~i_wave_mode_lo[0];
	assign force_b_nxt = wr_ctrl & i_wdata[`TCIP_BIT_FORCE_B] &
		~i_wave_mode_lo[0];
	assign hit_a = match_a | force_a_r;
	assign hit_b = match_b | force_b_r;

	// Overflow point per waveform mode
	assign ovf_set = tick & (is_phase ?
		(dir_r == TCIP_DIR_DN && cnt_r == `TCIP_BOTTOM) :
		(wave_mode == `TCIP_MODE_FAST_OCR) ? at_top :
		cnt_r == `TCIP_MAX);

	// Flags: bit 2 compare B, bit 1 compare A, bit 0 overflow
	assign flag_set = {match_b, match_a, ovf_set};
	assign flag_clr = ({3{wr_flags}} &
		i_wdata[`TCIP_BIT_IRQ_B:`TCIP_BIT_IRQ_OVF]) |
		{i_vec_ack_cmp_b, i_vec_ack_cmp_a, i_vec_ack_ovf};
	assign flag_nxt = {flag_next(flag_r[2], flag_set[2], flag_clr[2]),
		flag_next(flag_r[1], flag_set[1], flag_clr[1]),
		flag_next(flag_r[0], flag_set[0], flag_clr[0])};

	// Prescaler reset self-clears unless sync mode holds it
	assign psr_nxt = wr_sync ? i_wdata[`TCIP_BIT_PSR] :
		psr_r & tsm_r;

	// Read mux; reserved and force bits read as zero
	assign rd_mux =
		(i_addr == `TCIP_ADDR_CTRL_B) ? {4'h0, wgm2_r, clk_sel_r} :
		(i_addr == `TCIP_ADDR_CNT)    ? cnt_r :
		(i_addr == `TCIP_ADDR_OCR_A)  ? ocr_a_r :
		(i_addr == `TCIP_ADDR_OCR_B)  ? ocr_b_r :
		(i_addr == `TCIP_ADDR_MASK)   ? {4'h0, mask_r, 1'b0} :
		(i_addr == `TCIP_ADDR_FLAGS)  ? {4'h0, flag_r, 1'b0} :
		(i_addr == `TCIP_ADDR_SYNC)   ? {tsm_r, 6'h00, psr_r} :
		`TCIP_RST_BYTE;

	// Counter sequence; a software write beats the tick
	always_comb begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		if (wr_cnt) begin
			cnt_nxt = i_wdata;
		end else if (tick && is_phase) begin
			case (dir_r)
				TCIP_DIR_UP: begin
					if (at_top) begin
						dir_nxt = TCIP_DIR_DN;
						cnt_nxt = cnt_r - `TCIP_ONE;
					end else begin
						cnt_nxt = cnt_r + `TCIP_ONE;
					end
				end
				TCIP_DIR_DN: begin
					if (cnt_r == `TCIP_BOTTOM) begin
						dir_nxt = TCIP_DIR_UP;
						cnt_nxt = cnt_r + `TCIP_ONE;
					end else begin
						cnt_nxt = cnt_r - `TCIP_ONE;
					end
				end
				default: begin
					dir_nxt = TCIP_DIR_UP;
				end
			endcase
		end else if (tick) begin
			// Only a real tick at top wraps; a force cannot clear
			cnt_nxt = at_top ? `TCIP_BOTTOM : cnt_r + `TCIP_ONE;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cnt_r <= `TCIP_RST_BYTE;
			dir_r <= TCIP_DIR_UP;
			blk_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			dir_r <= dir_nxt;
			blk_r <= wr_cnt | (blk_r & ~tick);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			clk_sel_r <= `TCIP_RST_SEL;
			wgm2_r    <= 1'b0;
			force_a_r <= 1'b0;
			force_b_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				clk_sel_r <= i_wdata[`TCIP_CS_MSB:0];
				wgm2_r    <= i_wdata[`TCIP_BIT_WGM2];
			end
			force_a_r <= force_a_nxt;
			force_b_r <= force_b_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ocr_a_r <= `TCIP_RST_BYTE;
			ocr_b_r <= `TCIP_RST_BYTE;
			mask_r  <= '0;
			flag_r  <= '0;
			psr_r   <= 1'b0;
			tsm_r   <= 1'b0;
		end else begin
			if (wr_ocr_a) begin
				ocr_a_r <= i_wdata;
			end
			if (wr_ocr_b) begin
				ocr_b_r <= i_wdata;
			end
			if (wr_mask) begin
				mask_r <= i_wdata[`TCIP_BIT_IRQ_B:`TCIP_BIT_IRQ_OVF];
			end
			if (wr_sync) begin
				tsm_r <= i_wdata[`TCIP_BIT_TSM];
			end
			flag_r <= flag_nxt;
			psr_r  <= psr_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			irq_r    <= '0;
			rdata_r  <= `TCIP_RST_BYTE;
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else begin
			irq_r    <= {3{i_global_irq_en}} & flag_r & mask_r;
			rdata_r  <= i_rd ? rd_mux : `TCIP_RST_BYTE;
			wave_a_r <= wave_next(wave_a_r, i_out_mode_a, hit_a, top_evt,
				is_pwm, is_phase, dir_r == TCIP_DIR_UP, wgm2_r);
			wave_b_r <= wave_next(wave_b_r, i_out_mode_b, hit_b, top_evt,
				is_pwm, is_phase, dir_r == TCIP_DIR_UP, 1'b0);
		end
	end

	assign o_rdata      = rdata_r;
	assign o_irq_cmp_b  = irq_r[2];
	assign o_irq_cmp_a  = irq_r[1];
	assign o_irq_ovf    = irq_r[0];
	assign o_wave_out_a = wave_a_r;
	assign o_wave_out_b = wave_b_r;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	a_ctrl_read_zero:
	assert property (i_rd && i_addr == `TCIP_ADDR_CTRL_B |=>
		o_rdata[7:4] == 4'h0)
		else $error("control read shows force or reserved bits");
	a_force_strobe:
	assert property (wr_ctrl && i_wdata[7] && !i_wave_mode_lo[0] |=>
		force_a_r ##1 (!force_a_r || $past(wr_ctrl)))
		else $error("force A strobe missing or too long");
	a_force_pwm_off:
	assert property (wr_ctrl && i_wave_mode_lo[0] |=>
		!force_a_r && !force_b_r)
		else $error("force strobe acted in PWM mode");
	a_force_no_flag:
	assert property (force_a_r && !match_a && !flag_r[1] |=> !flag_r[1])
		else $error("forced compare set compare A flag");
	a_flag_b_set:
	assert property (tick && !blk_r && eq_b |=> flag_r[2])
		else $error("compare B match lost");
	a_flag_a_set:
	assert property (tick && !blk_r && eq_a |=> flag_r[1])
		else $error("compare A match lost");
	a_ovf_normal:
	assert property (tick && wave_mode == `TCIP_MODE_NORMAL &&
		cnt_r == `TCIP_MAX |=> flag_r[0])
		else $error("overflow flag not set at max");
	a_flag_w0_keep:
	assert property (wr_flags && !i_wdata[3] && !i_vec_ack_cmp_b &&
		flag_r[2] |=> flag_r[2])
		else $error("writing zero cleared compare B flag");
	a_cnt_block:
	assert property (wr_cnt ##1 (tick && !wr_cnt) |-> !match_a && !match_b)
		else $error("compare match not blocked after write");
	a_cnt_write:
	assert property (wr_cnt |=> cnt_r == $past(i_wdata))
		else $error("counter write lost to tick");
	a_direct_count:
	assert property (clk_sel_r == `TCIP_CS_DIRECT && !psr_r && !wr_cnt &&
		wave_mode == `TCIP_MODE_NORMAL |=>
		cnt_r == 8'($past(cnt_r) + `TCIP_ONE))
		else $error("undivided clock did not count");
	a_psr_clear:
	assert property (psr_r && !tsm_r && !wr_sync |=> !psr_r)
		else $error("prescaler reset did not self clear");
	a_psr_hold:
	assert property (psr_r && tsm_r && !wr_sync |=> psr_r && !tick)
		else $error("sync mode let prescaler reset go");
	a_irq_request:
	assert property (i_global_irq_en && flag_r[0] && mask_r[0] |=> o_irq_ovf)
		else $error("overflow interrupt not requested");
	a_pin_latency:
	assert property ($rose(i_ext_count_pin) |-> ##2 tick_if.ext_rise)
		else $error("count pin edge not seen in time");

	c_force_a: cover property (force_a_r);
	c_overflow: cover property (ovf_set);
	c_pin_tick: cover property (tick && clk_sel_r == `TCIP_CS_EXT_RISE);
	c_sync_hold: cover property (psr_r && tsm_r ##1 !tsm_r);
endmodule

/* tcip_timer_tb.sv */
// Self-checking bench for the timer register block
`include "tcip_consts.svh"
module tcip_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tcip_pkg::*;

	logic       clk;
	logic       rst;
	tcip_addr_t addr;
	tcip_byte_t wdata;
	logic       wr_s;
	logic       rd_s;
	logic [1:0] wave_lo;
	logic [1:0] om_a;
	logic [1:0] om_b;
	logic       pin;
	logic       gie;
	logic       ack_a;
	logic       ack_b;
	logic       ack_ovf;
	tcip_byte_t rdata;
	logic       irq_a;
	logic       irq_b;
	logic       irq_ovf;
	logic       wave_a;
	logic       wave_b;
	int         fail_count;
	int         samples_checked;

	tcip_timer tcip_timer_i (
		.i_sys_clk       (clk),
		.i_rst           (rst),
		.i_addr          (addr),
		.i_wdata         (wdata),
		.i_wr            (wr_s),
		.i_rd            (rd_s),
		.i_wave_mode_lo  (wave_lo),
		.i_out_mode_a    (om_a),
		.i_out_mode_b    (om_b),
		.i_ext_count_pin (pin),
		.i_global_irq_en (gie),
		.i_vec_ack_cmp_a (ack_a),
		.i_vec_ack_cmp_b (ack_b),
		.i_vec_ack_ovf   (ack_ovf),
		.o_rdata         (rdata),
		.o_irq_cmp_a     (irq_a),
		.o_irq_cmp_b     (irq_b),
		.o_irq_ovf       (irq_ovf),
		.o_wave_out_a    (wave_a),
		.o_wave_out_b    (wave_b)
	);

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk8(input tcip_byte_t got, input tcip_byte_t exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input tcip_addr_t a, input tcip_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'h1;
		@(posedge clk);
		wr_s <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input tcip_addr_t a, output tcip_byte_t d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge clk);
		rd_s <= 1'h0;
		#1;
		d = rdata;
	endtask

	task automatic rchk(input tcip_addr_t a, input tcip_byte_t exp);
		tcip_byte_t d;
		rd(a, d);
		chk8(d, exp);
	endtask

	// Counter advance across a window of gap plus two edges
	task automatic meas(input int gap, output tcip_byte_t diff);
		tcip_byte_t a;
		tcip_byte_t b;
		rd(`TCIP_ADDR_CNT, a);
		cycles(gap);
		rd(`TCIP_ADDR_CNT, b);
		diff = tcip_byte_t'(b - a);
	endtask

	task automatic t_reset;
		for (int a = 0; a < 8; a++) begin
			rchk(tcip_addr_t'(a), 8'h00);
		end
	endtask

	task automatic t_regs;
		wr(`TCIP_ADDR_CTRL_B, 8'hF8);
		rchk(`TCIP_ADDR_CTRL_B, 8'h08);
		wr(`TCIP_ADDR_CTRL_B, 8'h00);
		wr(`TCIP_ADDR_MASK, 8'hFF);
		rchk(`TCIP_ADDR_MASK, 8'h0E);
		wr(`TCIP_ADDR_MASK, 8'h00);
		wr(`TCIP_ADDR_FLAGS, 8'hFF);
		rchk(`TCIP_ADDR_FLAGS, 8'h00);
		wr(`TCIP_ADDR_OCR_A, 8'hA5);
		rchk(`TCIP_ADDR_OCR_A, 8'hA5);
		wr(`TCIP_ADDR_OCR_B, 8'h5A);
		rchk(`TCIP_ADDR_OCR_B, 8'h5A);
		wr(`TCIP_ADDR_CNT, 8'hC3);
		rchk(`TCIP_ADDR_CNT, 8'hC3);
		wr(3'h7, 8'hFF);
		rchk(3'h7, 8'h00);
	endtask

	// Any window of four periods holds four ticks, whatever the phase
	task automatic t_clksel;
		int divs[6] = '{0, 1, 8, 64, 256, 1024};
		tcip_byte_t d;
		for (int s = 0; s < 6; s++) begin
			wr(`TCIP_ADDR_CTRL_B, tcip_byte_t'(s));
			meas((s < 2) ? 2 : 4 * divs[s] - 2, d);
			chk8(d, (s == 0) ? 8'h00 : 8'h04);
		end
		wr(`TCIP_ADDR_CTRL_B, 8'h00);
	endtask

	// Pin is stable low whenever the source is switched
	task automatic t_pin;
		tcip_byte_t a;
		tcip_byte_t b;
		for (int s = 6; s < 8; s++) begin
			wr(`TCIP_ADDR_CTRL_B, tcip_byte_t'(s));
			rd(`TCIP_ADDR_CNT, a);
			repeat (3) begin
				@(posedge clk);
				pin <= 1'h1;
				cycles(3);
				pin <= 1'h0;
				cycles(3);
			end
			cycles(4);
			rd(`TCIP_ADDR_CNT, b);
			chk8(tcip_byte_t'(b - a), 8'h03);
			wr(`TCIP_ADDR_CTRL_B, 8'h00);
		end
	endtask

	task automatic t_cmp;
		wr(`TCIP_ADDR_OCR_A, 8'h20);
		wr(`TCIP_ADDR_OCR_B, 8'h22);
		wr(`TCIP_ADDR_MASK, 8'h0E);
		@(posedge clk);
		gie <= 1'h1;
		wr(`TCIP_ADDR_CNT, 8'h1E);
		wr(`TCIP_ADDR_CTRL_B, 8'h01);
		cycles(8);
		wr(`TCIP_ADDR_CTRL_B, 8'h00);
		rchk(`TCIP_ADDR_FLAGS, 8'h0C);
		chk1(irq_a, 1'h1);
		chk1(irq_b, 1'h1);
		chk1(irq_ovf, 1'h0);
		wr(`TCIP_ADDR_FLAGS, 8'h04);
		rchk(`TCIP_ADDR_FLAGS, 8'h08);
		chk1(irq_a, 1'h0);
		wr(`TCIP_ADDR_FLAGS, 8'h00);
		rchk(`TCIP_ADDR_FLAGS, 8'h08);
		@(posedge clk);
		ack_b <= 1'h1;
		@(posedge clk);
		ack_b <= 1'h0;
		rchk(`TCIP_ADDR_FLAGS, 8'h00);
		chk1(irq_b, 1'h0);
	endtask

	task automatic t_block;
		wr(`TCIP_ADDR_OCR_A, 8'h30);
		wr(`TCIP_ADDR_CNT, 8'h30);
		wr(`TCIP_ADDR_CTRL_B, 8'h01);
		cycles(4);
		wr(`TCIP_ADDR_CNT, 8'h50);
		wr(`TCIP_ADDR_CTRL_B, 8'h00);
		rchk(`TCIP_ADDR_FLAGS, 8'h00);
		rchk(`TCIP_ADDR_CNT, 8'h52);
	endtask

	task automatic t_ovf;
		wr(`TCIP_ADDR_CNT, 8'hFD);
		wr(`TCIP_ADDR_CTRL_B, 8'h01);
		cycles(6);
		wr(`TCIP_ADDR_CTRL_B, 8'h00);
		rchk(`TCIP_ADDR_FLAGS, 8'h02);
		chk1(irq_ovf, 1'h1);
		@(posedge clk);
		ack_ovf <= 1'h1;
		@(posedge clk);
		ack_ovf <= 1'h0;
		rchk(`TCIP_ADDR_FLAGS, 8'h00);
		chk1(irq_ovf, 1'h0);
	endtask

	// Clear-on-compare mode, so a forced match must not clear the counter
	task automatic t_force;
		logic [1:0] om[4] = '{2'h1, 2'h2, 2'h3, 2'h1};
		logic       ex[4] = '{1'h1, 1'h0, 1'h1, 1'h0};
		@(posedge clk);
		wave_lo <= 2'h2;
		wr(`TCIP_ADDR_CNT, 8'h05);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			om_a <= om[i];
			wr(`TCIP_ADDR_CTRL_B, 8'h80);
			cycles(3);
			chk1(wave_a, ex[i]);
		end
		@(posedge clk);
		om_b <= 2'h3;
		wr(`TCIP_ADDR_CTRL_B, 8'h40);
		cycles(3);
		chk1(wave_b, 1'h1);
		rchk(`TCIP_ADDR_FLAGS, 8'h00);
		rchk(`TCIP_ADDR_CNT, 8'h05);
		rchk(`TCIP_ADDR_CTRL_B, 8'h00);
		// PWM mode: software keeps both force bits at zero
		@(posedge clk);
		wave_lo <= 2'h3;
		wr(`TCIP_ADDR_CTRL_B, 8'h00);
		cycles(3);
		chk1(wave_a, 1'h0);
		@(posedge clk);
		wave_lo <= 2'h0;
	endtask

	task automatic t_psr;
		tcip_byte_t a;
		tcip_byte_t b;
		wr(`TCIP_ADDR_SYNC, 8'h01);
		rchk(`TCIP_ADDR_SYNC, 8'h00);
		wr(`TCIP_ADDR_SYNC, 8'h81);
		rchk(`TCIP_ADDR_SYNC, 8'h81);
		wr(`TCIP_ADDR_CTRL_B, 8'h01);
		meas(2, a);
		chk8(a, 8'h00);
		wr(`TCIP_ADDR_CTRL_B, 8'h02);
		rd(`TCIP_ADDR_CNT, a);
		wr(`TCIP_ADDR_SYNC, 8'h00);
		cycles(8);
		rd(`TCIP_ADDR_CNT, b);
		chk8(tcip_byte_t'(b - a), 8'h01);
		rchk(`TCIP_ADDR_SYNC, 8'h00);
		wr(`TCIP_ADDR_CTRL_B, 8'h00);
	endtask

	// Longest test is the divide-by-1024 window, about 4100 cycles
	initial begin
		#100000;
		fail_count++;
		final_report();
	end

	initial begin
		fail_count = 0;
		samples_checked = 0;
		rst = 1'h1;
		addr = 3'h0;
		wdata = 8'h00;
		wr_s = 1'h0;
		rd_s = 1'h0;
		wave_lo = 2'h0;
		om_a = 2'h0;
		om_b = 2'h0;
		pin = 1'h0;
		gie = 1'h0;
		ack_a = 1'h0;
		ack_b = 1'h0;
		ack_ovf = 1'h0;
		cycles(8);
		rst <= 1'h0;
		t_reset();
		t_regs();
		t_clksel();
		t_pin();
		t_cmp();
		t_block();
		t_ovf();
		t_force();
		t_psr();
		final_report();
	end
endmodule
